//--- include/csm_pkg.sv
package csm_pkg;

    // number of select lines: lines 0..10 plus the boot select at index 11
    localparam int          CSM_NUM_SEL     = 12;
    localparam int          CSM_BOOT_IDX    = 11;
    localparam int          CSM_PORT_LO     = 3;
    localparam int          CSM_PORT_HI     = 9;

    // register map, byte addresses on the wishbone port
    localparam logic [7:0]  CSM_OPT_BASE    = 8'h00;
    localparam logic [7:0]  CSM_BAR_BASE    = 8'h40;
    localparam logic [7:0]  CSM_PINS_OFS    = 8'h80;
    localparam logic [7:0]  CSM_PORT_OFS    = 8'h84;
    localparam logic [7:0]  CSM_STATUS_OFS  = 8'h88;

    // reset values
    localparam logic [15:0] CSM_OPT_RST     = 16'h0000;
    localparam logic [15:0] CSM_OPT_BOOT_RST = 16'h7b70;
    localparam logic [15:0] CSM_BAR_RST     = 16'h0000;
    localparam logic [15:0] CSM_BAR_BOOT_RST = 16'h0007;
    localparam logic [23:0] CSM_PINS_RST    = 24'hffffff;
    localparam logic [6:0]  CSM_PORT_RST    = 7'h00;

    // option field encodings
    localparam logic [1:0]  CSM_BYTE_OFF    = 2'h0;
    localparam logic [1:0]  CSM_BYTE_LOWER  = 2'h1;
    localparam logic [1:0]  CSM_BYTE_UPPER  = 2'h2;
    localparam logic [1:0]  CSM_RW_READ     = 2'h1;
    localparam logic [1:0]  CSM_RW_WRITE    = 2'h2;
    localparam logic [1:0]  CSM_RW_BOTH     = 2'h3;
    localparam logic [1:0]  CSM_SP_CPU      = 2'h0;
    localparam logic [1:0]  CSM_SP_USER     = 2'h1;
    localparam logic [1:0]  CSM_SP_SUPV     = 2'h2;
    localparam logic [3:0]  CSM_ACK_FAST    = 4'he;
    localparam logic [3:0]  CSM_ACK_EXT     = 4'hf;
    localparam logic [2:0]  CSM_FC_CPU      = 3'h7;
    localparam logic [3:0]  CSM_IACK_TYPE   = 4'hf;
    localparam logic [1:0]  CSM_SIZ_BYTE    = 2'h1;

    // internal acknowledge timing in clk_i cycles
    localparam logic [5:0]  CSM_ACK_BASE_CYC = 6'h02;
    localparam logic [5:0]  CSM_CYC_PER_WAIT = 6'h02;
    localparam logic [5:0]  CSM_FAST_CYC     = 6'h01;

    // pin assignment encodings
    typedef enum logic [1:0] {
        CSM_PIN_DISCRETE = 2'b00,
        CSM_PIN_ALT      = 2'b01,
        CSM_PIN_SEL8     = 2'b10,
        CSM_PIN_SEL16    = 2'b11
    } csm_pin_e_t;

    // option register layout
    typedef struct packed {
        logic       mode;
        logic [1:0] byte_en;
        logic [1:0] rw;
        logic       strobe_select;
        logic [3:0] data_size_ack;
        logic [1:0] space;
        logic [2:0] priority_mask;
        logic       autovector_request;
    } csm_opt_t;

    // base register layout: base address bits 23..11 and block size
    typedef struct packed {
        logic [12:0] base;
        logic [2:0]  block_size_field;
    } csm_bar_t;

    // external bus pins watched by the select logic
    typedef struct packed {
        logic [23:0] addr;
        logic [2:0]  function_code;
        logic        rw;
        logic [1:0]  transfer_size_bits;
        logic        addr_strobe_line_n;
        logic        data_strobe_n;
        logic        slow_bus_clock;
    } csm_bus_t;

    localparam logic [32:0] CSM_BUS_IDLE = 33'h00000000e;

endpackage : csm_pkg

//--- hdl/csm_sync.sv
`timescale 1ns/1ns
module csm_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // raw and filtered signals
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } csm_sync_st_t;

    csm_sync_st_t st_q, st_d;

    // three stages; a bit changes once the second and third agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.q;

endmodule : csm_sync

//--- hdl/csm_ack_timer.sv
`timescale 1ns/1ns
module csm_ack_timer
    import csm_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control
    input  wire logic       start_i,
    input  wire logic [3:0] waits_i,
    input  wire logic       clear_i,
    output logic            done_o
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       busy;
        logic       done;
    } csm_tmr_st_t;

    csm_tmr_st_t st_q, st_d;

    // load the wait count, count down, hold done until cleared
    always_comb begin
        st_d = st_q;
        if (clear_i) begin
            st_d = '0;
        end else if (start_i) begin
            st_d.busy = 1'b1;
            st_d.done = 1'b0;
            if (waits_i == CSM_ACK_FAST) begin
                st_d.cnt = CSM_FAST_CYC;
            end else begin
                st_d.cnt = 6'(CSM_ACK_BASE_CYC + CSM_CYC_PER_WAIT * 6'(waits_i));
            end
        end else if (st_q.busy) begin
            if (st_q.cnt == 6'h01) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
            st_d.cnt = 6'(st_q.cnt - 6'h01);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_o = st_q.done;

endmodule : csm_ack_timer

//--- hdl/csm_select.sv
`timescale 1ns/1ns
// Operation
// - mode bit picks async or slow-clock-aligned assertion
// - byte field: off, lower, upper, both
// - 8-bit port enables on any nonzero byte
// - reset clears byte fields, boot gets both
// - read/write field: reserved, read, write, both
// - strobe select picks address or data strobe in async mode
// - ack field: 0..13 waits, fast, external
// - space field: cpu, user, supervisor, either
// - cpu space compares priority, zero matches all
// - autovector bit gives internal autovector, pins only
// - discrete output lines 3..9 show latched port bit
// - compare address, direction, byte lanes per line
// - assert with strobe or with slow clock
// - internal ack after programmed waits in async mode only, else external
// - cpu space cycles compare base like others
// - no response to internal module acknowledge
// - autovector ends the acknowledge cycle
// - block size selects compared address lines
// - pin field: discrete, alternate, 8-bit, 16-bit
module csm_select
    import csm_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // external bus pins and interrupt context
    input  wire csm_pkg::csm_bus_t      ext_bus_i,
    input  wire logic                   iack_internal_i,
    input  wire logic                   irq_pin_source_i,
    // select and acknowledge outputs
    output logic [csm_pkg::CSM_NUM_SEL-1:0] select_n_o,
    output logic                        data_size_ack_n_o,
    output logic                        autovector_request_n_o
);
    import csm_pkg::*;

    typedef enum logic [1:0] {
        CSM_CYC_IDLE  = 2'b00,
        CSM_CYC_ADDR  = 2'b01,
        CSM_CYC_ACKED = 2'b10
    } csm_cyc_e_t;

    typedef struct packed {
        logic [CSM_NUM_SEL-1:0][15:0] opt;
        logic [CSM_NUM_SEL-1:0][15:0] bar;
        logic [23:0]                  pins;
        logic [6:0]                   port_out_bits;
        logic [CSM_NUM_SEL-1:0]       sel_n;
        logic [CSM_NUM_SEL-1:0]       sync_sel;
        logic                         data_size_ack_n;
        logic                         autovector_request_n;
        csm_cyc_e_t                   cyc;
        logic                         slow_bus_clock_prev;
        logic [31:0]                  rdata;
        logic                         ack;
    } csm_st_t;

    csm_st_t  st_q, st_d;
    csm_bus_t bus;
    logic     tmr_start;
    logic [3:0] tmr_waits;
    logic     tmr_clear;
    logic     tmr_done;

    // mask of base bits compared for a block size
    function automatic logic [12:0] blk_mask(input logic [2:0] bs);
        case (bs)
            3'h0:    blk_mask = 13'h1fff;
            3'h1:    blk_mask = 13'h1ffc;
            3'h2:    blk_mask = 13'h1ff8;
            3'h3:    blk_mask = 13'h1fe0;
            3'h4:    blk_mask = 13'h1fc0;
            3'h5:    blk_mask = 13'h1f80;
            3'h6:    blk_mask = 13'h1f00;
            3'h7:    blk_mask = 13'h1e00;
            default: blk_mask = 13'h1fff;
        endcase
    endfunction : blk_mask

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        lane_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                lane_merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : lane_merge

    // full qualification of one line against the current access
    function automatic logic line_match(input csm_opt_t  o,
                                        input csm_bar_t  br,
                                        input logic [1:0] pin,
                                        input csm_bus_t  b);
        logic m_addr;
        logic m_rw;
        logic m_byte;
        logic m_space;
        logic m_ipl;
        logic cpu_sp;
        logic iack;
        logic lower;
        logic upper;
        logic [12:0] mk;
        mk     = blk_mask(br.block_size_field);
        cpu_sp = (b.function_code == CSM_FC_CPU);
        iack   = cpu_sp && (b.addr[19:16] == CSM_IACK_TYPE);
        m_addr = ((b.addr[23:11] ^ br.base) & mk) == 13'h0000;
        case (o.rw)
            CSM_RW_READ:  m_rw = b.rw;
            CSM_RW_WRITE: m_rw = !b.rw;
            CSM_RW_BOTH:  m_rw = 1'b1;
            default:      m_rw = 1'b0;
        endcase
        lower = b.addr[0] || (b.transfer_size_bits != CSM_SIZ_BYTE);
        upper = !b.addr[0];
        if (o.byte_en == CSM_BYTE_OFF) begin
            m_byte = 1'b0;
        end else if (pin == CSM_PIN_SEL8) begin
            m_byte = 1'b1;
        end else if (o.byte_en == CSM_BYTE_LOWER) begin
            m_byte = lower;
        end else if (o.byte_en == CSM_BYTE_UPPER) begin
            m_byte = upper;
        end else begin
            m_byte = 1'b1;
        end
        case (o.space)
            CSM_SP_CPU:  m_space = cpu_sp;
            CSM_SP_USER: m_space = !b.function_code[2];
            CSM_SP_SUPV: m_space = b.function_code[2] && !cpu_sp;
            default:     m_space = !cpu_sp;
        endcase
        m_ipl = 1'b1;
        if (o.space == CSM_SP_CPU && iack) begin
            m_ipl = (o.priority_mask == 3'h0) || (o.priority_mask == b.addr[3:1]);
        end
        line_match = m_addr && m_rw && m_byte && m_space && m_ipl;
    endfunction : line_match

    // pin inputs filtered into the clock domain
    csm_sync #(
        .W       (33),
        .RST_VAL (CSM_BUS_IDLE)
    ) u_bus_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (ext_bus_i),
        .q_o   (bus)
    );

    // internal acknowledge wait counter
    csm_ack_timer u_ack_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (tmr_start),
        .waits_i (tmr_waits),
        .clear_i (tmr_clear),
        .done_o  (tmr_done)
    );

    // register file, select timing and cycle termination
    always_comb begin
        logic                   as_on;
        logic                   ds_on;
        logic                   slow_bus_clock_rise;
        logic                   iack;
        logic                   blocked;
        logic                   strobe_on;
        logic                   any_autovector_request;
        logic                   found;
        logic [CSM_NUM_SEL-1:0] m;
        logic [3:0]             idx;
        logic [31:0]            wv;
        csm_opt_t               o;
        as_on     = 1'b0;
        ds_on     = 1'b0;
        slow_bus_clock_rise = 1'b0;
        iack      = 1'b0;
        blocked   = 1'b0;
        strobe_on = 1'b0;
        any_autovector_request  = 1'b0;
        found     = 1'b0;
        m         = '0;
        idx       = 4'h0;
        wv        = 32'h00000000;
        o         = '0;
        st_d      = st_q;
        tmr_start = 1'b0;
        tmr_waits = 4'h0;
        tmr_clear = 1'b0;

        // wishbone: ack one cycle after the request, drop it the next
        st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
        if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
            st_d.rdata = 32'h00000000;
            if (wb_adr_i < CSM_BAR_BASE && wb_adr_i[7:2] < 6'(CSM_NUM_SEL)) begin
                st_d.rdata = {16'h0000, st_q.opt[wb_adr_i[5:2]]};
            end else if (wb_adr_i >= CSM_BAR_BASE && wb_adr_i < CSM_PINS_OFS
                         && wb_adr_i[5:2] < 4'(CSM_NUM_SEL)) begin
                st_d.rdata = {16'h0000, st_q.bar[wb_adr_i[5:2]]};
            end else if (wb_adr_i == CSM_PINS_OFS) begin
                st_d.rdata = {8'h00, st_q.pins};
            end else if (wb_adr_i == CSM_PORT_OFS) begin
                st_d.rdata = {25'h0000000, st_q.port_out_bits};
            end else if (wb_adr_i == CSM_STATUS_OFS) begin
                st_d.rdata = {16'h0000, st_q.cyc, st_q.autovector_request_n, st_q.data_size_ack_n,
                              st_q.sel_n};
            end
        end

        // writes land on the edge that drops ack
        if (wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack) begin
            if (wb_adr_i < CSM_BAR_BASE && wb_adr_i[7:2] < 6'(CSM_NUM_SEL)) begin
                wv = lane_merge({16'h0000, st_q.opt[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i);
                st_d.opt[wb_adr_i[5:2]] = wv[15:0];
            end else if (wb_adr_i >= CSM_BAR_BASE && wb_adr_i < CSM_PINS_OFS
                         && wb_adr_i[5:2] < 4'(CSM_NUM_SEL)) begin
                wv = lane_merge({16'h0000, st_q.bar[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i);
                st_d.bar[wb_adr_i[5:2]] = wv[15:0];
            end else if (wb_adr_i == CSM_PINS_OFS) begin
                wv = lane_merge({8'h00, st_q.pins}, wb_dat_i, wb_sel_i);
                st_d.pins = wv[23:0];
            end else if (wb_adr_i == CSM_PORT_OFS && wb_sel_i[0]) begin
                st_d.port_out_bits = wb_dat_i[6:0];
            end
        end

        // access decode on the filtered pins
        as_on          = !bus.addr_strobe_line_n;
        ds_on          = !bus.data_strobe_n;
        slow_bus_clock_rise      = bus.slow_bus_clock && !st_q.slow_bus_clock_prev;
        st_d.slow_bus_clock_prev = bus.slow_bus_clock;
        iack           = (bus.function_code == CSM_FC_CPU)
                         && (bus.addr[19:16] == CSM_IACK_TYPE);
        blocked        = iack && iack_internal_i;
        for (int i = 0; i < CSM_NUM_SEL; i++) begin
            m[i] = line_match(csm_opt_t'(st_q.opt[i]), csm_bar_t'(st_q.bar[i]),
                              st_q.pins[2*i +: 2], bus) && !blocked;
        end

        // per-line select timing and pin function
        for (int i = 0; i < CSM_NUM_SEL; i++) begin
            o = csm_opt_t'(st_q.opt[i]);
            if (!as_on) begin
                st_d.sync_sel[i] = 1'b0;
            end else if (slow_bus_clock_rise && m[i]) begin
                st_d.sync_sel[i] = 1'b1;
            end
            strobe_on = o.strobe_select ? ds_on : as_on;
            if (o.mode) begin
                st_d.sel_n[i] = !st_d.sync_sel[i];
            end else begin
                st_d.sel_n[i] = !(m[i] && strobe_on);
            end
            if (st_q.pins[2*i +: 2] == CSM_PIN_DISCRETE
                && i >= CSM_PORT_LO && i <= CSM_PORT_HI) begin
                st_d.sel_n[i] = st_q.port_out_bits[i - CSM_PORT_LO];
            end else if (st_q.pins[2*i +: 2] == CSM_PIN_ALT) begin
                st_d.sel_n[i] = 1'b1;
            end
            if (m[i] && o.autovector_request) begin
                any_autovector_request = 1'b1;
            end
            if (!found && m[i] && !o.mode && o.data_size_ack != CSM_ACK_EXT) begin
                found = 1'b1;
                idx   = 4'(i);
            end
        end

        // bus cycle tracking and termination
        case (st_q.cyc)
            CSM_CYC_IDLE: begin
                if (as_on) begin
                    st_d.cyc = CSM_CYC_ADDR;
                    if (found) begin
                        tmr_start = 1'b1;
                        o         = csm_opt_t'(st_q.opt[idx]);
                        tmr_waits = o.data_size_ack;
                    end
                end
            end
            CSM_CYC_ADDR: begin
                if (!as_on) begin
                    st_d.cyc  = CSM_CYC_IDLE;
                    tmr_clear = 1'b1;
                end else if (iack && irq_pin_source_i && any_autovector_request) begin
                    st_d.autovector_request_n = 1'b0;
                    st_d.cyc    = CSM_CYC_ACKED;
                end else if (tmr_done) begin
                    st_d.data_size_ack_n = 1'b0;
                    st_d.cyc     = CSM_CYC_ACKED;
                end
            end
            CSM_CYC_ACKED: begin
                if (!as_on) begin
                    st_d.cyc     = CSM_CYC_IDLE;
                    st_d.data_size_ack_n = 1'b1;
                    st_d.autovector_request_n  = 1'b1;
                    tmr_clear    = 1'b1;
                end
            end
            default: begin
                st_d.cyc  = CSM_CYC_IDLE;
                tmr_clear = 1'b1;
            end
        endcase
    end

    // state register with documented reset values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < CSM_NUM_SEL; i++) begin
                st_q.opt[i] <= CSM_OPT_RST;
                st_q.bar[i] <= CSM_BAR_RST;
            end
            st_q.opt[CSM_BOOT_IDX] <= CSM_OPT_BOOT_RST;
            st_q.bar[CSM_BOOT_IDX] <= CSM_BAR_BOOT_RST;
            st_q.pins          <= CSM_PINS_RST;
            st_q.port_out_bits <= CSM_PORT_RST;
            st_q.sel_n         <= '1;
            st_q.sync_sel      <= '0;
            st_q.data_size_ack_n       <= 1'b1;
            st_q.autovector_request_n        <= 1'b1;
            st_q.cyc           <= CSM_CYC_IDLE;
            st_q.slow_bus_clock_prev     <= 1'b0;
            st_q.rdata         <= 32'h00000000;
            st_q.ack           <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign wb_dat_o               = st_q.rdata;
    assign wb_ack_o               = st_q.ack;
    assign select_n_o             = st_q.sel_n;
    assign data_size_ack_n_o      = st_q.data_size_ack_n;
    assign autovector_request_n_o = st_q.autovector_request_n;

endmodule : csm_select

//--- verification/csm_select_props.sv
`timescale 1ns/1ns
module csm_select_props
    import csm_pkg::*;
(
    // clock, reset and register bus
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    // external bus side
    input wire csm_pkg::csm_bus_t ext_bus_i,
    input wire logic              iack_internal_i,
    input wire logic              irq_pin_source_i,
    input wire logic [11:0]       select_n_o,
    input wire logic              data_size_ack_n_o,
    input wire logic              autovector_request_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // both strobes released long enough to pass the pin filter
    sequence idle_s;
        (ext_bus_i.addr_strobe_line_n && ext_bus_i.data_strobe_n) [*6];
    endsequence
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_no_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    port_top_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CSM_PORT_OFS |->
        !wb_dat_o[7]) else $error("port bit 7 set");
    release_idle_a: assert property (idle_s |-> select_n_o[2:0] == 3'h7 &&
        select_n_o[11:10] == 2'h3 && data_size_ack_n_o && autovector_request_n_o)
        else $error("select held after strobes");
    select_strobe_a: assert property ($fell(select_n_o[0]) || $fell(select_n_o[11]) |->
        !$past(ext_bus_i.addr_strobe_line_n, 3) || !$past(ext_bus_i.data_strobe_n, 3))
        else $error("select without strobe");
    ack_needs_as_a: assert property ($fell(data_size_ack_n_o) |->
        !$past(ext_bus_i.addr_strobe_line_n, 3)) else $error("ack outside cycle");
    autovector_request_source_a: assert property ($fell(autovector_request_n_o) |-> $past(irq_pin_source_i) &&
        $past(ext_bus_i.function_code, 3) == CSM_FC_CPU) else $error("bad autovector");
    iack_inner_a: assert property (iack_internal_i [*3] |->
        autovector_request_n_o && data_size_ack_n_o) else $error("answered internal iack");
endmodule : csm_select_props

//--- verification/csm_periph.sv
`timescale 1ns/1ns
module csm_periph
    import csm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // selects seen by the memories and a sample request
    input  wire logic [11:0] select_n_i,
    input  wire logic        sample_i,
    output logic      [11:0] hit_o,
    output logic             done_o
);
    logic [11:0] seen_q;
    // gather every line pulled low since the last sample
    always_ff @(posedge clk_i) begin
        seen_q <= (rst_i || sample_i) ? 12'h000 : (seen_q | ~select_n_i);
        done_o <= sample_i && !rst_i;
        hit_o  <= seen_q | ~select_n_i;
    end
endmodule : csm_periph

//--- verification/csm_select_test.sv
`timescale 1ns/1ns
module csm_select_test;
    import csm_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    csm_bus_t    ext_bus_i = CSM_BUS_IDLE;
    logic        iack_internal_i = 1'b0, irq_pin_source_i = 1'b0, sample = 1'b0;
    logic        done, ack_n, autovector_request_n, ok;
    logic [11:0] select_n_o, hit;
    logic [31:0] v, rng = 32'd83665;
    logic [1:0]  sp;
    logic [3:0]  codes [4] = '{4'h0, 4'hd, 4'he, 4'hf};
    logic [63:0] exp_rd [$];
    logic [11:0] exp_hit [$];
    int          failures = 0;
    int          n_compared = 0;
    csm_select u_csm_select (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_bus_i, .iack_internal_i,
        .irq_pin_source_i, .select_n_o, .data_size_ack_n_o(ack_n),
        .autovector_request_n_o(autovector_request_n));
    csm_periph u_csm_periph (.clk_i, .rst_i, .select_n_i(select_n_o), .sample_i(sample),
        .hit_o(hit), .done_o(done));
    // free running clock
    initial forever #4 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_hit(input logic [11:0] got, input logic [11:0] exp);
        cmp_rd({20'h0, got}, {20'h0, exp});
    endtask : cmp_hit
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
        exp_rd.push_back({m, e});
        wb(1'b0, adr, 32'h0);
    endtask : rd
    task automatic go(input logic [23:0] a, input logic [2:0] f, input logic r);
        @(posedge clk_i);
        ext_bus_i <= '{a, f, r, CSM_SIZ_BYTE, 1'b0, 1'b0, 1'b0};
        repeat (10) @(posedge clk_i);
    endtask : go
    task automatic stop(input logic [11:0] e);
        exp_hit.push_back(e);
        @(posedge clk_i);
        {ext_bus_i.addr_strobe_line_n, ext_bus_i.data_strobe_n} <= 2'h3;
        repeat (8) @(posedge clk_i);
        sample <= 1'b1;
        @(posedge clk_i);
        sample <= 1'b0;
    endtask : stop
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // result watcher: oldest note against each answer
    always @(posedge clk_i) begin
        logic [63:0] m;
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_rd.size() > 0) begin
            m = exp_rd.pop_front();
            cmp_rd(wb_dat_o & m[63:32], m[31:0]);
        end
        if (done === 1'b1 && exp_hit.size() > 0) cmp_hit(hit, exp_hit.pop_front());
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CSM_OPT_BASE, 32'hffff, 32'h0);
        rd(CSM_OPT_BASE + 8'h2c, 32'hffff, 32'h7b70);
        rd(CSM_BAR_BASE + 8'h2c, 32'hffff, 32'h7);
        rd(CSM_PINS_OFS, 32'hffffff, 32'hffffff);
        wb(1'b1, CSM_PORT_OFS, 32'hff);
        rd(CSM_PORT_OFS, 32'hff, 32'h7f);
        rd(8'hfc, 32'hffffffff, 32'h0);
        go(24'h0, 3'h6, 1'b1);
        stop(12'h800);
        wb(1'b1, CSM_BAR_BASE, 32'h4007);
        for (int i = 0; i < 24; i++) begin
            v = xs();
            sp = (v[5:4] == 2'h0) ? 2'h3 : v[5:4];
            wb(1'b1, CSM_PINS_OFS, {8'h0, 22'h3fffff, 1'b1, v[8]});
            wb(1'b1, CSM_OPT_BASE, {17'h0, v[1:0], v[3:2], 5'h0, sp, 4'h0});
            ok = (v[8] ? v[1:0] == 2'h3 || v[1:0] == {!v[9], v[9]} : v[1:0] != 2'h0)
                && (v[10] ? v[2] : v[3]) && (sp == 2'h3 || sp[1] == v[6]);
            go({4'h4, v[30:12], v[9]}, {v[6], v[7] ? 2'h1 : 2'h2}, v[10]);
            stop({11'h0, ok});
        end
        foreach (codes[k]) begin
            wb(1'b1, CSM_OPT_BASE, 32'h7830 | (codes[k] << 6));
            go(24'h400000, 3'h5, 1'b1);
            rd(CSM_STATUS_OFS, 32'h1000, {19'h0, codes[k] == 4'hf || codes[k] == 4'hd, 12'h0});
            repeat (30) @(posedge clk_i);
            rd(CSM_STATUS_OFS, 32'h1000, {19'h0, codes[k] == 4'hf, 12'h0});
            stop(12'h001);
        end
        wb(1'b1, CSM_BAR_BASE + 8'h04, 32'hfffb);
        for (int i = 0; i < 16; i++) begin
            v = xs();
            wb(1'b1, CSM_OPT_BASE + 8'h04, {16'h0, 12'h2bc, v[2:0], 1'b1});
            iack_internal_i <= v[3];
            irq_pin_source_i <= v[4];
            go({20'hfffff, v[7:5], 1'b1}, CSM_FC_CPU, 1'b1);
            ok = (v[2:0] == 3'h0 || v[2:0] == v[7:5]) && !v[3];
            rd(CSM_STATUS_OFS, 32'h2002, {18'h0, !(ok && v[4]), 11'h0, !ok, 1'b0});
            stop({10'h0, ok, 1'b0});
        end
        wb(1'b1, CSM_PINS_OFS, 32'hffff3f);
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, CSM_PORT_OFS, i);
            rd(CSM_STATUS_OFS, 32'h8, {28'h0, i[0], 3'h0});
        end
        report_and_stop();
    end
endmodule : csm_select_test
bind csm_select csm_select_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .ext_bus_i, .iack_internal_i, .irq_pin_source_i,
    .select_n_o, .data_size_ack_n_o, .autovector_request_n_o);
